// >>> inc/rops_regs.svh
// register offsets, field positions and reset values of the output pin select block
`ifndef ROPS_REGS_SVH
`define ROPS_REGS_SVH

`define ROPS_SEL_PINS_10_11_OFFSET 8'h00
`define ROPS_SEL_PINS_12_13_OFFSET 8'h04
`define ROPS_SEL_PINS_14_15_OFFSET 8'h08
`define ROPS_SEL_PINS_16_17_OFFSET 8'h0c
`define ROPS_LOW_FIELD_LSB 0
`define ROPS_HIGH_FIELD_LSB 8
`define ROPS_SEL_WIDTH 5
`define ROPS_FIELD_MASK 16'h1f1f
`define ROPS_SEL_RESET 5'h00
`define ROPS_CODE_NONE 5'h00
`define ROPS_RESP_OKAY 2'h0
`define ROPS_RESP_SLVERR 2'h2

`endif

// >>> inc/rops_pkg.sv
// types shared by the output pin select block
`default_nettype none
package rops_pkg;
  typedef logic [4:0] rops_code_t;
  typedef logic [15:0] rops_reg_t;
endpackage : rops_pkg
`default_nettype wire

// >>> hw/rops_out_select.sv
// remappable output pin select: selector registers on AXI4-Lite and output muxes
`timescale 1ns/1ps
`default_nettype none
`include "rops_regs.svh"
// Function
// - pin 10 driven by register0 bits 4-0
// - pin 11 driven by register0 bits 12-8
// - pin 12 driven by register1 bits 4-0
// - pin 13 driven by register1 bits 12-8
// - pin 14 driven by register2 bits 4-0
// - pin 15 driven by register2 bits 12-8
// - pin 16 driven by register3 bits 4-0
// - pin 17 driven by register3 bits 12-8
// - bits 15-13, 7-5 read zero, ignore writes
// - selectors read/write, clear to zero at reset
// - fourth register only in large package build
module rops_out_select import rops_pkg::*; #(
  parameter int NUM_PERIPH = 32,
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic ARST_N_IN,
  // axi4-lite write address
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [7:0] AWADDR_IN,
  // axi4-lite write data
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  // axi4-lite write response
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  output logic [1:0] BRESP_OUT,
  // axi4-lite read address
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  input wire logic [7:0] ARADDR_IN,
  // axi4-lite read data
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  // peripheral outputs indexed by function code, and pad side
  input wire logic [NUM_PERIPH-1:0] PERIPH_OUT_IN,
  output logic [7:0] REMAP_PIN_OUT,
  output logic [7:0] REMAP_PIN_EN_OUT
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // a 5-bit code cannot address more than 32 sources
  if (NUM_PERIPH < 1 || NUM_PERIPH > 32) begin : g_bad_periph
    $error("NUM_PERIPH must lie in 1..32");
  end

  // ****************************************
  // selector storage
  // ****************************************
  rops_code_t sel_q [8];
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // 0..3 for a mapped register, 4 when unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    logic [2:0] idx;
    idx = 3'h4;
    case (addr)
      `ROPS_SEL_PINS_10_11_OFFSET: idx = 3'h0;
      `ROPS_SEL_PINS_12_13_OFFSET: idx = 3'h1;
      `ROPS_SEL_PINS_14_15_OFFSET: idx = 3'h2;
      `ROPS_SEL_PINS_16_17_OFFSET: idx = LARGE_PACKAGE ? 3'h3 : 3'h4;
      default: idx = 3'h4;
    endcase
    return idx;
  endfunction : reg_index

  // ****************************************
  // write channel
  // ****************************************
  logic wr_fire;
  logic [2:0] wr_idx;
  assign wr_fire = aw_held_q && w_held_q && !BVALID_OUT;
  assign wr_idx = reg_index(awaddr_q);

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (AWVALID_IN && AWREADY_OUT) begin
      aw_held_q <= 1'b1;
      awaddr_q <= AWADDR_IN;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (WVALID_IN && WREADY_OUT) begin
      w_held_q <= 1'b1;
      wdata_q <= WDATA_IN;
      wstrb_q <= WSTRB_IN;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // ready registered: high only while the channel's holding slot is empty
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      AWREADY_OUT <= 1'b0;
      WREADY_OUT <= 1'b0;
    end else begin
      AWREADY_OUT <= !(aw_held_q || (AWVALID_IN && AWREADY_OUT)) || wr_fire;
      WREADY_OUT <= !(w_held_q || (WVALID_IN && WREADY_OUT)) || wr_fire;
      if (AWVALID_IN && AWREADY_OUT) begin
        AWREADY_OUT <= 1'b0;
      end
      if (WVALID_IN && WREADY_OUT) begin
        WREADY_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      BVALID_OUT <= 1'b0;
      BRESP_OUT <= `ROPS_RESP_OKAY;
    end else if (wr_fire) begin
      BVALID_OUT <= 1'b1;
      BRESP_OUT <= (wr_idx == 3'h4) ? `ROPS_RESP_SLVERR : `ROPS_RESP_OKAY;
    end else if (BREADY_IN) begin
      BVALID_OUT <= 1'b0;
    end
  end

  // byte lane 0 holds the low selector, lane 1 the high one
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (int i = 0; i < 8; i++) begin
        sel_q[i] <= `ROPS_SEL_RESET;
      end
    end else if (wr_fire && wr_idx != 3'h4) begin
      if (wstrb_q[0]) begin
        sel_q[{wr_idx[1:0], 1'b0}] <= wdata_q[`ROPS_LOW_FIELD_LSB +: `ROPS_SEL_WIDTH];
      end
      if (wstrb_q[1]) begin
        sel_q[{wr_idx[1:0], 1'b1}] <= wdata_q[`ROPS_HIGH_FIELD_LSB +: `ROPS_SEL_WIDTH];
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  logic [2:0] rd_idx;
  rops_reg_t rd_word;
  assign rd_idx = reg_index(ARADDR_IN);
  // unimplemented bits are simply never stored, so they read zero
  assign rd_word = {3'h0, sel_q[{rd_idx[1:0], 1'b1}], 3'h0, sel_q[{rd_idx[1:0], 1'b0}]};

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ARREADY_OUT <= 1'b0;
    end else begin
      ARREADY_OUT <= !RVALID_OUT && !(ARVALID_IN && ARREADY_OUT);
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      RVALID_OUT <= 1'b0;
      RDATA_OUT <= 32'h0000_0000;
      RRESP_OUT <= `ROPS_RESP_OKAY;
    end else if (ARVALID_IN && ARREADY_OUT) begin
      RVALID_OUT <= 1'b1;
      if (rd_idx == 3'h4) begin
        RDATA_OUT <= 32'h0000_0000;
        RRESP_OUT <= `ROPS_RESP_SLVERR;
      end else begin
        RDATA_OUT <= {16'h0000, rd_word & `ROPS_FIELD_MASK};
        RRESP_OUT <= `ROPS_RESP_OKAY;
      end
    end else if (RREADY_IN) begin
      RVALID_OUT <= 1'b0;
    end
  end

  // ****************************************
  // output multiplexers
  // ****************************************
  // nonzero code c selects PERIPH_OUT_IN[c]; code 0 and codes past the table drive nothing
  function automatic logic pick(input rops_code_t code, input logic [NUM_PERIPH-1:0] src);
    logic v;
    v = 1'b0;
    if (code != `ROPS_CODE_NONE && int'(code) < NUM_PERIPH) begin
      v = src[code];
    end
    return v;
  endfunction : pick

  function automatic logic claimed(input rops_code_t code);
    return code != `ROPS_CODE_NONE && int'(code) < NUM_PERIPH;
  endfunction : claimed

  // registered so pads see a glitch-free level; costs one cycle of latency
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      REMAP_PIN_OUT <= 8'h00;
      REMAP_PIN_EN_OUT <= 8'h00;
    end else begin
      for (int p = 0; p < 8; p++) begin
        // pins 16 and 17 stay with the port in the small build
        if (p < 6 || LARGE_PACKAGE) begin
          REMAP_PIN_OUT[p] <= pick(sel_q[p], PERIPH_OUT_IN);
          REMAP_PIN_EN_OUT[p] <= claimed(sel_q[p]);
        end else begin
          REMAP_PIN_OUT[p] <= 1'b0;
          REMAP_PIN_EN_OUT[p] <= 1'b0;
        end
      end
    end
  end

endmodule : rops_out_select
`default_nettype wire

// >>> tb/rops_out_select_assertions.sv
// checker for the output pin select block
`timescale 1ns/1ps
`default_nettype none
module rops_out_select_checker #(
  parameter int NUM_PERIPH = 32
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic ARST_N_IN,
  // register bus
  input wire logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [1:0] BRESP_OUT,
  input wire logic ARVALID_IN,
  input wire logic ARREADY_OUT,
  input wire logic RVALID_OUT,
  input wire logic [31:0] RDATA_OUT,
  input wire logic [1:0] RRESP_OUT,
  // pads
  input wire logic [NUM_PERIPH-1:0] PERIPH_OUT_IN,
  input wire logic [7:0] REMAP_PIN_OUT,
  input wire logic [7:0] REMAP_PIN_EN_OUT
);
  // ********
  // checks
  // ********
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  rd_lat_a: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
    else $error("read late");
  ar_block_a: assert property (RVALID_OUT |-> !ARREADY_OUT)
    else $error("read overlap");
  rd_zero_a: assert property (RVALID_OUT |-> (RDATA_OUT & 32'hffffe0e0) == 32'h0)
    else $error("spare bits set");
  err_zero_a: assert property (RVALID_OUT && RRESP_OUT == 2'h2 |-> RDATA_OUT == 32'h0)
    else $error("error read data");
  wr_hold_a: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
    else $error("response dropped");
  pin_off_a: assert property ((REMAP_PIN_OUT & ~REMAP_PIN_EN_OUT) == 8'h0)
    else $error("unclaimed pin high");
  pin_hi_a: assert property (&$past(PERIPH_OUT_IN) |-> REMAP_PIN_OUT == REMAP_PIN_EN_OUT)
    else $error("claimed pin low");
  pin_lo_a: assert property (~|$past(PERIPH_OUT_IN) |-> REMAP_PIN_OUT == 8'h0)
    else $error("pin high");
endmodule : rops_out_select_checker
bind rops_out_select rops_out_select_checker #(.NUM_PERIPH(NUM_PERIPH)) rops_out_select_checker_inst (
  .CORE_CLK_IN, .ARST_N_IN, .BVALID_OUT, .BREADY_IN, .BRESP_OUT, .ARVALID_IN, .ARREADY_OUT,
  .RVALID_OUT, .RDATA_OUT, .RRESP_OUT, .PERIPH_OUT_IN, .REMAP_PIN_OUT, .REMAP_PIN_EN_OUT);
`default_nettype wire

// >>> tb/rops_out_select_test.sv
// bench for the output pin select block
`timescale 1ns/1ps
`default_nettype none
module rops_out_select_test;
  logic clk = '0, rst_n = '0, awv = '0, wv = '0, arv = '0, br = '0, rr = '0;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] bs, rs;
  logic [3:0] ws = 4'hf;
  logic [7:0] aa = '0, ra = '0, pin, pen, pin2, pen2;
  logic awr2, wrd2, bv2, arr2, rv2;
  logic [1:0] bs2, rs2;
  logic [31:0] rdat2;
  logic [31:0] wd = '0, pi = '0, rdat, e;
  logic [4:0] cd [8] = '{5'h01, 5'h1f, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03, 5'h00};
  int bad_count = 0, check_count = 0;
  rops_out_select rops_out_select_inst (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n),
    .AWVALID_IN(awv), .AWREADY_OUT(awr), .AWADDR_IN(aa), .WVALID_IN(wv), .WREADY_OUT(wrd),
    .WDATA_IN(wd), .WSTRB_IN(ws), .BVALID_OUT(bv), .BREADY_IN(br), .BRESP_OUT(bs),
    .ARVALID_IN(arv), .ARREADY_OUT(arr), .ARADDR_IN(ra), .RVALID_OUT(rv), .RREADY_IN(rr),
    .RDATA_OUT(rdat), .RRESP_OUT(rs), .PERIPH_OUT_IN(pi), .REMAP_PIN_OUT(pin),
    .REMAP_PIN_EN_OUT(pen));
  // small build shares the stimulus; only its pads are compared
  rops_out_select #(.LARGE_PACKAGE(1'b0)) rops_out_select_small_inst (.CORE_CLK_IN(clk),
    .ARST_N_IN(rst_n), .AWVALID_IN(awv), .AWREADY_OUT(awr2), .AWADDR_IN(aa), .WVALID_IN(wv),
    .WREADY_OUT(wrd2), .WDATA_IN(wd), .WSTRB_IN(ws), .BVALID_OUT(bv2), .BREADY_IN(br),
    .BRESP_OUT(bs2), .ARVALID_IN(arv), .ARREADY_OUT(arr2), .ARADDR_IN(ra), .RVALID_OUT(rv2),
    .RREADY_IN(rr), .RDATA_OUT(rdat2), .RRESP_OUT(rs2), .PERIPH_OUT_IN(pi),
    .REMAP_PIN_OUT(pin2), .REMAP_PIN_EN_OUT(pen2));
  // ********
  // tasks
  // ********
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 64) begin
      bad_count++;
      close_out();
    end
  endtask : tick
  // one write or read; d is write data or expected read data
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    int n = 0;
    logic pa = 1'h1;
    logic pw = w;
    @(posedge clk);
    aa <= a;
    ra <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    arv <= !w;
    rr <= !w;
    while (pa | pw) begin
      tick(n);
      if (w ? awr === 1'h1 : arr === 1'h1) pa = 1'h0;
      if (wrd === 1'h1) pw = 1'h0;
      awv <= w & pa;
      arv <= !w & pa;
      wv <= pw;
    end
    while ((w ? bv : rv) !== 1'h1) tick(n);
    // bready comes a cycle late so the held response is exercised
    if (w) begin
      br <= 1'h1;
      tick(n);
    end
    br <= 1'h0;
    rr <= 1'h0;
    if (!w) chk(rdat, d);
    chk(32'(w ? bs : rs), 32'(r));
  endtask : bus
  initial forever #2.5 clk = ~clk;
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 4; i++) bus('0, 8'(4 * i), '0, '0);
    chk(32'(pen), '0);
    $display("reset test done");
    for (int i = 0; i < 8; i += 2) bus('1, 8'(2 * i), {19'h7ffff, cd[i+1], 3'h7, cd[i]}, '0);
    for (int i = 0; i < 8; i += 2) bus('0, 8'(2 * i), {19'h0, cd[i+1], 3'h0, cd[i]}, '0);
    $display("register test done");
    for (int c = 0; c < 33; c++) begin
      pi <= c < 32 ? 32'h1 << c : '1;
      repeat (2) @(posedge clk);
      e = '0;
      for (int k = 0; k < 8; k++) e[k] = (cd[k] == c[4:0] || c == 32) && cd[k] != 5'h0;
      chk(32'(pin), e);
      chk(32'(pin2), e & 32'h3f);
    end
    chk(32'(pen), 32'h7f);
    chk(32'(pen2), 32'h3f);
    $display("pin test done");
    ws <= 4'h2;
    bus('1, 8'h04, '0, '0);
    ws <= 4'hf;
    bus('0, 8'h04, 32'h2, '0);
    bus('1, 8'h10, 32'h1f1f, 2'h2);
    bus('0, 8'h10, '0, 2'h2);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    bus('0, 8'h00, '0, '0);
    $display("bus test done");
    close_out();
  end
endmodule : rops_out_select_test
`default_nettype wire
